// ==== hdl/gpio_port_defs.vh ====
// register indices, field positions, codes and reset values for the port pin controller
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

// register indices (byte address = index * 4)
`define IDX_IRQ_ENABLE_MAIN     7'h23
`define IDX_IRQ_FLAG_MAIN       7'h26
`define IDX_PORT1_PIN_DATA      7'h70
`define IDX_PORT1_EDGE_SELECT   7'h74
`define IDX_PORT4_PIN_DATA      7'h75
`define IDX_PORT4_DIRECTION     7'h76
`define IDX_PORT4_ANALOG_ENABLE 7'h77
`define IDX_PORT4_PULLUP_ENABLE 7'h78
`define IDX_PORT4_PULLDOWN_A    7'h79
`define IDX_PORT4_PULLDOWN_B    7'h7A
`define IDX_PORT4_EDGE_SELECT   7'h7B
`define IDX_PORT4_IRQ_ENABLE    7'h7C
`define IDX_PORT4_IRQ_FLAG      7'h7D
`define IDX_PORT4_OUTPUT_MODE   7'h7E
`define IDX_IRQ_STATUS          7'h60
`define IDX_IRQ_CLEAR           7'h61
`define IDX_IRQ_MASK            7'h62

// bus geometry
`define ADR_IDX_HI 8
`define ADR_IDX_LO 2

// field positions
`define BIT_GLOBAL_EN    7
`define BIT_PIN0_IRQ     0
`define BIT_PWM_B_ROUTE  6
`define BIT_PWM_A_ROUTE  4
`define SHARE_HI         1
`define SHARE_LO         0
`define BIT_PIN6         6
`define BIT_PIN7         7
`define P4_HI            7
`define P4_LO            3
`define PD_A_HI          7
`define PD_A_LO          6
`define EDGE_SEL_HI      1
`define EDGE_SEL_LO      0

// edge detector arming: the shift covers both sync stages and the first real sample
`define ARM_HI    2
`define ARM_CLEAR 3'h0

// pin positions inside the five-wide port vectors (pin 3 at index 0)
`define PIN4 1
`define PIN5 2
`define PIN6 3
`define PIN7 4

// codes
`define EDGE_FALL   2'b00
`define EDGE_RISE   2'b01
`define SHARE_UART  2'b01
`define SHARE_I2C   2'b10

// reset values
`define RST_BYTE 8'h00
`define RST_P4   5'h00
`define RST_MASK 8'hFF
`define ZERO32   32'h00000000

`endif

// ==== hdl/pin_sync.v ====
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 6
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // levels
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // pin_sync

// ==== hdl/edge_detect.v ====
// selectable edge detector on a synchronised pin level
`timescale 1ns/1ps
`include "gpio_port_defs.vh"
module edge_detect (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // level and edge choice
  input  wire       level_i,
  input  wire [1:0] sel_i,
  output wire       event_o
);

  reg             prev_reg;
  reg [`ARM_HI:0] arm_reg;

  // the sync flops leave reset at 0, so an idle-high pin would fake a rise;
  // arm only once prev holds a sample that came through both sync stages
  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
      arm_reg  <= `ARM_CLEAR;
    end else begin
      prev_reg <= level_i;
      arm_reg  <= {arm_reg[`ARM_HI-1:0], 1'b1};
    end
  end

  wire armed = arm_reg[`ARM_HI];
  wire rise  = armed & ~prev_reg & level_i;
  wire fall  = armed & prev_reg & ~level_i;

  // 00 falling, 01 rising, 1x either edge
  assign event_o = (sel_i == `EDGE_FALL) ? fall :
                   (sel_i == `EDGE_RISE) ? rise : (rise | fall);

endmodule // edge_detect

// ==== hdl/gpio_port_pin_control.v ====
// port pin controller: input pin, five-pin bidirectional port, pin interrupts, wishbone registers
// register map: index = byte address / 4, one byte per access in dat[7:0]
//   0x23 irq_enable_main      bit7 global enable, bit0 input pin event enable
//   0x26 irq_flag_main        bit0 input pin event flag, other bits plain storage
//   0x60 irq status           read only: bit7 pin 7, bit6 pin 6, bit0 input pin
//   0x61 irq clear            write only, a 1 clears the matching flag
//   0x62 irq mask             same layout as status, resets to all ones
//   0x70 port1_pin_data       bit0 live level of the input pin, writes ignored
//   0x74 port1_edge_select    bits 1:0 edge choice for the input pin
//   0x75 port4_pin_data       bits 7:3, read gives level or latch by direction
//   0x76 port4_direction      bits 7:3, 1 drives the pin
//   0x77 port4_analog_enable  bits 7:3, 1 hands the pin to its analog channel
//   0x78 port4_pullup_enable  bits 7:3
//   0x79 port4_pulldown_sel_a bits 7:6 for pin 3
//   0x7A port4_pulldown_sel_b two bits a pin, pin 7 in bits 7:6 down to pin 4
//   0x7B port4_edge_select    bits 7:6, 0 falling, 1 rising
//   0x7C port4_irq_enable     bits 7:6
//   0x7D port4_irq_flag       bits 7:6, set by an edge, cleared by software
//   0x7E port4_output_mode    bit6 pulse b to pin 7, bit4 pulse a to pin 6
//                             bits 1:0 shared pins, code 11 behaves as 00
//   unmapped indices answer like any other and read as zero
//
// timing: ack comes one cycle after the request is taken
// pins pass two sync flops, so an edge reaches its flag about three clocks later;
// pulses shorter than a clock may be missed entirely
//
// limitations:
// i2c lines are pushed as plain data from the peripheral, not open drain
// a flag written directly takes the written value, yet an edge in that cycle sets it
// read data is captured on the edge that raises ack, before a write would land
// pin drive and enable are registered, so they follow the registers one clock late
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "gpio_port_defs.vh"
module gpio_port_pin_control (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [8:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output wire        ack_o,
  // interrupt
  output wire        irq_o,
  // first port pin
  input  wire        first_port_pin_i,
  output wire        first_port_pullup_o,
  // second port pins 7..3 (index 0 is pin 3)
  input  wire [4:0]  pin_i,
  output reg  [4:0]  pin_o,
  output reg  [4:0]  pin_oe_o,
  output wire [4:0]  pin_analog_enable_o,
  output wire [4:0]  pin_pullup_o,
  output wire [9:0]  pin_pulldown_select_o,
  // peripherals sharing the pins
  input  wire        pulse_width_out_a_i,
  input  wire        pulse_width_out_b_i,
  input  wire        serial_tx_i,
  output wire        serial_receive_pin_o,
  input  wire        i2c_scl_out_i,
  input  wire        i2c_sda_out_i,
  output wire        i2c_scl_in_o,
  output wire        i2c_sda_in_o,
  output wire        external_irq_source_zero_o
);

  // register bytes
  reg [7:0] irq_enable_main_reg;
  reg [7:0] irq_flag_main_reg;
  reg [7:0] port1_edge_select_reg;
  reg [4:0] port4_pin_data_reg;
  reg [4:0] port4_direction_reg;
  reg [4:0] port4_analog_enable_reg;
  reg [4:0] port4_pullup_enable_reg;
  reg [7:0] port4_pulldown_sel_a_reg;
  reg [7:0] port4_pulldown_sel_b_reg;
  reg [7:0] port4_edge_select_reg;
  reg [7:0] port4_irq_enable_reg;
  reg [7:0] port4_irq_flag_reg;
  reg [7:0] port4_output_mode_reg;
  reg [7:0] irq_mask_reg;
  reg       ack_reg;

  // widen a five-bit port field back to its byte position
  function [7:0] port_byte;
    input [4:0] f;
    begin
      port_byte = {f, 3'b000};
    end
  endfunction

  // register index compare
  function hit;
    input [6:0] idx;
    input [6:0] target;
    begin
      hit = (idx == target);
    end
  endfunction

  // synchronised pins: bit 5 is the first port pin
  wire [5:0] pins_sync;
  pin_sync #(.W(6)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({first_port_pin_i, pin_i}),
    .sync_o  (pins_sync)
  );
  wire       pin0_level = pins_sync[5];
  wire [4:0] p4_level   = pins_sync[4:0];

  // edge detectors
  wire ev_pin0;
  wire ev_pin6;
  wire ev_pin7;
  edge_detect u_edge0 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (pin0_level),
    .sel_i   (port1_edge_select_reg[`EDGE_SEL_HI:`EDGE_SEL_LO]),
    .event_o (ev_pin0)
  );
  edge_detect u_edge6 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (p4_level[`PIN6]),
    .sel_i   ({1'b0, port4_edge_select_reg[`BIT_PIN6]}),
    .event_o (ev_pin6)
  );
  edge_detect u_edge7 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (p4_level[`PIN7]),
    .sel_i   ({1'b0, port4_edge_select_reg[`BIT_PIN7]}),
    .event_o (ev_pin7)
  );

  // bus decode
  wire [6:0] idx     = adr_i[`ADR_IDX_HI:`ADR_IDX_LO];
  wire       req     = cyc_i & stb_i;
  wire       wr      = req & we_i & ack_reg & sel_i[0];
  wire [7:0] wb      = dat_i[7:0];
  wire [1:0] share   = port4_output_mode_reg[`SHARE_HI:`SHARE_LO];
  wire       clr_wr  = wr & hit(idx, `IDX_IRQ_CLEAR);

  // analog pins read as zero on the digital side
  wire [4:0] dig_in  = p4_level & ~port4_analog_enable_reg;

  // input pins show the live level, output pins the latched data
  wire [4:0] p4_read = (dig_in & ~port4_direction_reg) |
                       (port4_pin_data_reg & port4_direction_reg);

  // status view: pin flags gathered in one byte, same layout as clear and mask
  wire [7:0] irq_status = {port4_irq_flag_reg[`BIT_PIN7], port4_irq_flag_reg[`BIT_PIN6], 5'h00,
                           irq_flag_main_reg[`BIT_PIN0_IRQ]};

  // ack one cycle after the request; a write lands at the ack edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end
  assign ack_o = ack_reg;

  // read data captured when the ack is raised; unmapped indices read zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= `ZERO32;
    end else if (req & ~ack_reg) begin
      case (idx)
        `IDX_IRQ_ENABLE_MAIN:     dat_o <= {24'h000000, irq_enable_main_reg};
        `IDX_IRQ_FLAG_MAIN:       dat_o <= {24'h000000, irq_flag_main_reg};
        `IDX_PORT1_PIN_DATA:      dat_o <= {31'h00000000, pin0_level};
        `IDX_PORT1_EDGE_SELECT:   dat_o <= {24'h000000, port1_edge_select_reg};
        `IDX_PORT4_PIN_DATA:      dat_o <= {24'h000000, port_byte(p4_read)};
        `IDX_PORT4_DIRECTION:     dat_o <= {24'h000000, port_byte(port4_direction_reg)};
        `IDX_PORT4_ANALOG_ENABLE: dat_o <= {24'h000000, port_byte(port4_analog_enable_reg)};
        `IDX_PORT4_PULLUP_ENABLE: dat_o <= {24'h000000, port_byte(port4_pullup_enable_reg)};
        `IDX_PORT4_PULLDOWN_A:    dat_o <= {24'h000000, port4_pulldown_sel_a_reg};
        `IDX_PORT4_PULLDOWN_B:    dat_o <= {24'h000000, port4_pulldown_sel_b_reg};
        `IDX_PORT4_EDGE_SELECT:   dat_o <= {24'h000000, port4_edge_select_reg};
        `IDX_PORT4_IRQ_ENABLE:    dat_o <= {24'h000000, port4_irq_enable_reg};
        `IDX_PORT4_IRQ_FLAG:      dat_o <= {24'h000000, port4_irq_flag_reg};
        `IDX_PORT4_OUTPUT_MODE:   dat_o <= {24'h000000, port4_output_mode_reg};
        `IDX_IRQ_STATUS:          dat_o <= {24'h000000, irq_status};
        `IDX_IRQ_MASK:            dat_o <= {24'h000000, irq_mask_reg};
        default:                  dat_o <= `ZERO32;
      endcase
    end
  end

  // plain configuration registers; only implemented bits are stored, except 0x23 and the mask, which keep the whole byte
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable_main_reg      <= `RST_BYTE;
      port1_edge_select_reg    <= `RST_BYTE;
      port4_pin_data_reg       <= `RST_P4;
      port4_direction_reg      <= `RST_P4;
      port4_analog_enable_reg  <= `RST_P4;
      port4_pullup_enable_reg  <= `RST_P4;
      port4_pulldown_sel_a_reg <= `RST_BYTE;
      port4_pulldown_sel_b_reg <= `RST_BYTE;
      port4_edge_select_reg    <= `RST_BYTE;
      port4_irq_enable_reg     <= `RST_BYTE;
      port4_output_mode_reg    <= `RST_BYTE;
      irq_mask_reg             <= `RST_MASK;
    end else if (wr) begin
      if (hit(idx, `IDX_IRQ_ENABLE_MAIN))
        irq_enable_main_reg <= wb;
      if (hit(idx, `IDX_PORT1_EDGE_SELECT))
        port1_edge_select_reg <= {6'h00, wb[`EDGE_SEL_HI:`EDGE_SEL_LO]};
      if (hit(idx, `IDX_PORT4_PIN_DATA))
        port4_pin_data_reg <= wb[`P4_HI:`P4_LO];
      if (hit(idx, `IDX_PORT4_DIRECTION))
        port4_direction_reg <= wb[`P4_HI:`P4_LO];
      if (hit(idx, `IDX_PORT4_ANALOG_ENABLE))
        port4_analog_enable_reg <= wb[`P4_HI:`P4_LO];
      if (hit(idx, `IDX_PORT4_PULLUP_ENABLE))
        port4_pullup_enable_reg <= wb[`P4_HI:`P4_LO];
      if (hit(idx, `IDX_PORT4_PULLDOWN_A))
        port4_pulldown_sel_a_reg <= {wb[`PD_A_HI:`PD_A_LO], 6'h00};
      if (hit(idx, `IDX_PORT4_PULLDOWN_B))
        port4_pulldown_sel_b_reg <= wb;
      if (hit(idx, `IDX_PORT4_EDGE_SELECT))
        port4_edge_select_reg <= {wb[`BIT_PIN7:`BIT_PIN6], 6'h00};
      if (hit(idx, `IDX_PORT4_IRQ_ENABLE))
        port4_irq_enable_reg <= {wb[`BIT_PIN7:`BIT_PIN6], 6'h00};
      if (hit(idx, `IDX_PORT4_OUTPUT_MODE))
        port4_output_mode_reg <= {1'b0, wb[`BIT_PWM_B_ROUTE], 1'b0, wb[`BIT_PWM_A_ROUTE],
                                  2'b00, wb[`SHARE_HI:`SHARE_LO]};
      if (hit(idx, `IDX_IRQ_MASK))
        irq_mask_reg <= wb;
    end
  end

  // flags: a hardware event in the same cycle as a software clear wins
  reg [7:0] irq_flag_main_next;
  reg [7:0] port4_irq_flag_next;
  always @* begin
    irq_flag_main_next  = irq_flag_main_reg;
    port4_irq_flag_next = port4_irq_flag_reg;
    if (wr & hit(idx, `IDX_IRQ_FLAG_MAIN))
      irq_flag_main_next = wb;
    if (wr & hit(idx, `IDX_PORT4_IRQ_FLAG))
      port4_irq_flag_next = {wb[`BIT_PIN7:`BIT_PIN6], 6'h00};
    if (clr_wr) begin
      irq_flag_main_next[`BIT_PIN0_IRQ] = irq_flag_main_next[`BIT_PIN0_IRQ] & ~wb[`BIT_PIN0_IRQ];
      port4_irq_flag_next[`BIT_PIN6]    = port4_irq_flag_next[`BIT_PIN6] & ~wb[`BIT_PIN6];
      port4_irq_flag_next[`BIT_PIN7]    = port4_irq_flag_next[`BIT_PIN7] & ~wb[`BIT_PIN7];
    end
    if (ev_pin0)
      irq_flag_main_next[`BIT_PIN0_IRQ] = 1'b1;
    if (ev_pin6)
      port4_irq_flag_next[`BIT_PIN6] = 1'b1;
    if (ev_pin7)
      port4_irq_flag_next[`BIT_PIN7] = 1'b1;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_flag_main_reg  <= `RST_BYTE;
      port4_irq_flag_reg <= `RST_BYTE;
    end else begin
      irq_flag_main_reg  <= irq_flag_main_next;
      port4_irq_flag_reg <= port4_irq_flag_next;
    end
  end

  // pin 0 needs its own enable and the global enable; pins 6/7 their own enable
  wire req_pin0 = irq_status[`BIT_PIN0_IRQ] & irq_enable_main_reg[`BIT_PIN0_IRQ] &
                  irq_enable_main_reg[`BIT_GLOBAL_EN] & irq_mask_reg[`BIT_PIN0_IRQ];
  wire req_pin6 = irq_status[`BIT_PIN6] & port4_irq_enable_reg[`BIT_PIN6] &
                  irq_mask_reg[`BIT_PIN6];
  wire req_pin7 = irq_status[`BIT_PIN7] & port4_irq_enable_reg[`BIT_PIN7] &
                  irq_mask_reg[`BIT_PIN7];
  assign irq_o = req_pin0 | req_pin6 | req_pin7;

  // output data per pin: peripheral when selected, otherwise the data latch
  reg [4:0] pin_out_next;
  always @* begin
    pin_out_next = port4_pin_data_reg;
    if (share == `SHARE_UART)
      pin_out_next[`PIN5] = serial_tx_i;
    else if (share == `SHARE_I2C) begin
      pin_out_next[`PIN4] = i2c_scl_out_i;
      pin_out_next[`PIN5] = i2c_sda_out_i;
    end
    if (port4_output_mode_reg[`BIT_PWM_A_ROUTE])
      pin_out_next[`PIN6] = pulse_width_out_a_i;
    if (port4_output_mode_reg[`BIT_PWM_B_ROUTE])
      pin_out_next[`PIN7] = pulse_width_out_b_i;
  end

  // registered pad drive; analog pins never drive, direction gates the rest
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_o    <= `RST_P4;
      pin_oe_o <= `RST_P4;
    end else begin
      pin_o    <= pin_out_next;
      pin_oe_o <= port4_direction_reg & ~port4_analog_enable_reg;
    end
  end

  // pad configuration straight from the registers; the input pin pull-up is tied on
  assign pin_analog_enable_o   = port4_analog_enable_reg;
  assign pin_pullup_o          = port4_pullup_enable_reg;
  assign pin_pulldown_select_o = {port4_pulldown_sel_b_reg,
                                  port4_pulldown_sel_a_reg[`PD_A_HI:`PD_A_LO]};
  assign first_port_pullup_o   = 1'b1;

  // peripheral receive paths: idle high when their function is not selected
  assign serial_receive_pin_o       = (share == `SHARE_UART) ? dig_in[`PIN4] : 1'b1;
  assign i2c_scl_in_o               = (share == `SHARE_I2C) ? dig_in[`PIN4] : 1'b1;
  assign i2c_sda_in_o               = (share == `SHARE_I2C) ? dig_in[`PIN5] : 1'b1;
  assign external_irq_source_zero_o = pin0_level;

endmodule // gpio_port_pin_control

// ==== tb/gpio_port_pin_control_props.sv ====
// port-level assertions for the port pin controller
`timescale 1ns/1ps
module gpio_port_pin_control_props (
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // bus
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  // pins
  input wire        first_port_pin_i,
  input wire        first_port_pullup_o,
  input wire [4:0]  pin_oe_o,
  input wire [4:0]  pin_analog_enable_o,
  input wire [4:0]  pin_pullup_o,
  input wire [9:0]  pin_pulldown_select_o,
  input wire        serial_receive_pin_o,
  input wire        i2c_scl_in_o,
  input wire        external_irq_source_zero_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request not yet answered, and the one-cycle answer
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence
  property p_ack_next;
    s_req |=> s_ack_pulse;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus answer late or long");
  property p_read_upper;
    ack_o |-> dat_o[31:8] == 24'h000000;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper read bits set");
  property p_pullup_fixed;
    first_port_pullup_o;
  endproperty
  a_pullup_fixed: assert property (p_pullup_fixed) else $error("input pin pull-up off");
  // oe lags the register by one edge, so compare with last cycle's analog enables
  property p_analog_off;
    (pin_oe_o & $past(pin_analog_enable_o)) == 5'h00;
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog pin driven");
  property p_pullup_by_write;
    !$stable(pin_pullup_o) |-> $past(ack_o && we_i);
  endproperty
  a_pullup_by_write: assert property (p_pullup_by_write) else $error("pull-up moved alone");
  property p_pulldown_by_write;
    !$stable(pin_pulldown_select_o) |-> $past(ack_o && we_i);
  endproperty
  a_pulldown_by_write: assert property (p_pulldown_by_write) else $error("pull-down moved alone");
  // two sync flops: skip the edges whose history reaches into reset
  property p_first_sync;
    !$past(rst_i) && !$past(rst_i, 2) |-> external_irq_source_zero_o == $past(first_port_pin_i, 2);
  endproperty
  a_first_sync: assert property (p_first_sync) else $error("input pin sync wrong");
  property p_rx_scl_apart;
    !serial_receive_pin_o |-> i2c_scl_in_o;
  endproperty
  a_rx_scl_apart: assert property (p_rx_scl_apart) else $error("pin4 given to two users");
endmodule // gpio_port_pin_control_props

bind gpio_port_pin_control gpio_port_pin_control_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
  .first_port_pin_i(first_port_pin_i), .first_port_pullup_o(first_port_pullup_o), .pin_oe_o(pin_oe_o),
  .pin_analog_enable_o(pin_analog_enable_o), .pin_pullup_o(pin_pullup_o),
  .pin_pulldown_select_o(pin_pulldown_select_o), .serial_receive_pin_o(serial_receive_pin_o),
  .i2c_scl_in_o(i2c_scl_in_o), .external_irq_source_zero_o(external_irq_source_zero_o));

// ==== tb/pin_partner.sv ====
// external circuitry on the port pins: drivers, pulls and a floating-pin pattern
`timescale 1ns/1ps
module pin_partner (
  // clock
  input  wire        clk_i,
  // device side
  input  wire [4:0]  dout_i,
  input  wire [4:0]  oe_i,
  input  wire [4:0]  pu_i,
  input  wire [9:0]  pd_i,
  input  wire        pu1_i,
  // bench side
  input  wire [4:0]  ext_en_i,
  input  wire [4:0]  ext_val_i,
  input  wire        ext1_en_i,
  input  wire        ext1_val_i,
  // resolved levels
  output logic [4:0] lvl_o,
  output logic       lvl1_o
);
  logic [4:0] drift = 5'h0A;
  // a floating pin toggles every cycle so a stale value never passes
  always @(posedge clk_i) drift <= ~drift;
  // wire level: driver first, then the bench, then the pulls
  always_comb
    for (int i = 0; i < 5; i++)
      if (oe_i[i]) lvl_o[i] = dout_i[i];
      else if (ext_en_i[i]) lvl_o[i] = ext_val_i[i];
      else if (pu_i[i]) lvl_o[i] = 1'b1;
      else if (pd_i[2*i+:2] != 2'b00) lvl_o[i] = 1'b0;
      else lvl_o[i] = drift[i];
  assign lvl1_o = ext1_en_i ? ext1_val_i : (pu1_i ? 1'b1 : drift[0]);
endmodule // pin_partner

// ==== tb/gpio_port_pin_control_test.sv ====
// self-checking bench for the port pin controller
`timescale 1ns/1ps
module gpio_port_pin_control_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [8:0]  adr_i = 9'h000;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h00000000;
  logic        pwm_a = 1'b0;
  logic        pwm_b = 1'b0;
  logic        tx = 1'b1;
  logic        scl_out = 1'b1;
  logic        sda_out = 1'b1;
  logic [4:0]  ext_en = 5'h1F;
  logic [4:0]  ext_val = 5'h00;
  logic        ext1_en = 1'b0;
  logic        ext1_val = 1'b1;
  wire  [31:0] dat_o;
  wire         ack_o, irq_o, pu1, rx, scl_in, sda_in, lvl1;
  wire  [4:0]  pin_o, oe, an, pu, lvl;
  wire  [9:0]  pd;
  int          num_errors = 0;
  int          n_tests = 0;
  logic [7:0]  rdata;
  logic [6:0]  ridx [15] = '{7'h23, 7'h26, 7'h74, 7'h75, 7'h76, 7'h77, 7'h78, 7'h79, 7'h7A, 7'h7B,
                             7'h7C, 7'h7D, 7'h7E, 7'h60, 7'h10};

  always #25 clk_i = ~clk_i;

  gpio_port_pin_control u_gpio_port_pin_control (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .first_port_pin_i(lvl1),
    .first_port_pullup_o(pu1), .pin_i(lvl), .pin_o(pin_o), .pin_oe_o(oe), .pin_analog_enable_o(an),
    .pin_pullup_o(pu), .pin_pulldown_select_o(pd), .pulse_width_out_a_i(pwm_a), .pulse_width_out_b_i(pwm_b),
    .serial_tx_i(tx), .serial_receive_pin_o(rx), .i2c_scl_out_i(scl_out), .i2c_sda_out_i(sda_out),
    .i2c_scl_in_o(scl_in), .i2c_sda_in_o(sda_in), .external_irq_source_zero_o());

  pin_partner u_pin_partner (
    .clk_i(clk_i), .dout_i(pin_o), .oe_i(oe), .pu_i(pu), .pd_i(pd), .pu1_i(pu1), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .ext1_en_i(ext1_en), .ext1_val_i(ext1_val), .lvl_o(lvl), .lvl1_o(lvl1));

  task chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // one classic cycle; the request stands until ack is sampled high
  task wb(input logic w, input logic [6:0] idx, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rdata = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task wr(input logic [6:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
  endtask

  task rd(input logic [6:0] idx, input logic [7:0] exp, input string msg);
    wb(1'b0, idx, 8'h00);
    chk(10'(rdata), 10'(exp), msg);
  endtask

  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // about 330 cycles of tests; some ninety times that can only be a hang
  initial begin
    wt(30000);
    num_errors++;
    report_and_stop;
  end

  initial begin
    wt(12);
    rst_i <= 1'b0;
    wt(1);
    // reset values, an unmapped place and the live input pin
    rd(7'h62, 8'hFF, "mask reset");
    foreach (ridx[i]) rd(ridx[i], 8'h00, "reset value");
    rd(7'h70, 8'h01, "input pin pulled high");
    wr(7'h10, 8'h55);
    rd(7'h10, 8'h00, "unmapped");
    sel_i <= 4'h0;
    wr(7'h78, 8'hF8);
    sel_i <= 4'hF;
    rd(7'h78, 8'h00, "no byte lane");
    wr(7'h70, 8'h00);
    rd(7'h70, 8'h01, "live level kept");
    $display("test registers done");
    // drive, read back, pulls
    wr(7'h76, 8'hF8);
    ext_en <= 5'h00;
    wr(7'h75, 8'hA8);
    wt(1);
    chk(10'(oe), 10'h01F, "drivers on");
    chk(10'(pin_o), 10'h015, "drive levels");
    rd(7'h75, 8'hA8, "output readback");
    wr(7'h76, 8'h00);
    ext_val <= 5'h0A;
    ext_en <= 5'h1F;
    wt(3);
    rd(7'h75, 8'h50, "input levels");
    ext_en <= 5'h00;
    wr(7'h78, 8'hF8);
    wt(3);
    chk(10'(pu), 10'h01F, "pull-ups");
    rd(7'h75, 8'hF8, "pulled high");
    wr(7'h79, 8'hC0);
    wr(7'h7A, 8'h1B);
    chk(pd, 10'h06F, "pull-down codes");
    $display("test pins done");
    // analog pin: driver off, digital read zero
    wr(7'h76, 8'hF8);
    wr(7'h77, 8'h08);
    wt(1);
    chk(10'(an), 10'h001, "analog enable");
    chk(10'(oe), 10'h01E, "analog driver off");
    wr(7'h76, 8'hF0);
    rd(7'h75, 8'hA0, "analog reads zero");
    wr(7'h77, 8'h00);
    $display("test analog done");
    // every shared-pin code with both pulse routes on
    wr(7'h76, 8'hE8);
    wr(7'h75, 8'h20);
    ext_val <= 5'h00;
    ext_en <= 5'h02;
    for (int m = 0; m < 4; m++) begin
      pwm_a <= m[0];
      pwm_b <= ~m[0];
      // in codes 00 to 10 the selected pin 5 source differs from the other two, so a wrong source shows
      tx <= m[1];
      sda_out <= m[0];
      wr(7'h7E, {6'h14, m[1:0]});
      wt(3);
      chk(10'(pin_o[4:3]), 10'({~m[0], m[0]}), "pulse routes");
      chk(10'(pin_o[2]), 10'(m == 0 || m == 3), "pin5 source");
      if (m != 1) chk(10'(pin_o[1]), 10'(m == 2), "pin4 source");
      chk(10'(rx), 10'(m != 1), "receive line");
      chk(10'(scl_in), 10'(m != 2), "clock line");
      chk(10'(sda_in), 10'(m != 2), "data line");
      chk(10'(oe), 10'h01D, "direction kept");
    end
    wr(7'h7E, 8'h00);
    wt(1);
    chk(10'(pin_o[4:3]), 10'h000, "routes off");
    $display("test routing done");
    // pin 6 and 7 events, enable, mask and clear
    wr(7'h76, 8'h00);
    ext_en <= 5'h1F;
    wr(7'h7B, 8'h80);
    wr(7'h7C, 8'h40);
    wt(4);
    wr(7'h61, 8'hC1);
    ext_val <= 5'h18;
    wt(5);
    rd(7'h7D, 8'h80, "rise on pin7 only");
    chk(10'(irq_o), 10'h000, "pin7 not enabled");
    ext_val <= 5'h00;
    wt(5);
    rd(7'h7D, 8'hC0, "fall on pin6");
    chk(10'(irq_o), 10'h001, "pin6 request");
    rd(7'h60, 8'hC0, "status");
    wr(7'h62, 8'hBF);
    chk(10'(irq_o), 10'h000, "masked");
    wr(7'h62, 8'hFF);
    chk(10'(irq_o), 10'h001, "unmasked");
    wr(7'h61, 8'h40);
    chk(10'(irq_o), 10'h000, "cleared");
    rd(7'h7D, 8'h80, "pin7 flag kept");
    wr(7'h61, 8'h80);
    rd(7'h60, 8'h00, "all clear");
    wr(7'h7D, 8'hFF);
    rd(7'h7D, 8'hC0, "flag written");
    chk(10'(irq_o), 10'h001, "written flag request");
    wr(7'h61, 8'hC0);
    $display("test port events done");
    // every edge code on the input pin, then the global enable
    wr(7'h23, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(7'h74, {6'h00, c[1:0]});
      wr(7'h61, 8'h01);
      ext1_val <= 1'b0;
      ext1_en <= 1'b1;
      wt(5);
      rd(7'h26, {7'h00, c != 1}, "falling edge");
      chk(10'(irq_o), 10'h000, "global off");
      wr(7'h61, 8'h01);
      ext1_en <= 1'b0;
      wt(5);
      rd(7'h26, {7'h00, c != 0}, "rising edge");
    end
    wr(7'h23, 8'h81);
    chk(10'(irq_o), 10'h001, "global on");
    $display("test input pin done");
    report_and_stop;
  end
endmodule // gpio_port_pin_control_test
